// file: rtl/mdsr_top.sv
// Serial control port, reset supervisor and driver gating.
// Assumes comparator levels and pins arrive asynchronously; the serial
// clock runs only inside frames.
`timescale 1ns/1ps

// ----------------------------------------
// Pin synchroniser
// ----------------------------------------
module mdsr_pin_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end
        else
        begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit counts only once two settled stages agree.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            level_o <= RST_VAL;
        end
        else
        begin
            for (int i = 0; i < W; i++)
            begin
                if (s2_q[i] == s3_q[i])
                begin
                    level_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // mdsr_pin_sync

// ----------------------------------------
// Top level
// ----------------------------------------
module mdsr_top
#(
    parameter int unsigned RELEASE_CYCLES = mdsr_pkg::RELEASE_CYC,
    parameter int unsigned PERSIST_CYCLES = mdsr_pkg::PERSIST_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        serial_clk_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        shift_data_in_i,
    input  wire logic        first_regulator_feedback_low_i,
    input  wire logic        first_regulator_feedback_high_i,
    input  wire logic        main_supply_input_low_i,
    input  wire logic        main_supply_input_high_i,
    input  wire logic        reset_n_i,
    output logic             reset_n_o,
    output logic             reset_oe_o,
    input  wire logic [1:0]  driver_mode_select_i,
    input  wire logic [1:0]  driver_pwm_input_i,
    output logic [12:0]      control_word_o,
    output logic             second_regulator_and_drive_on_o,
    output logic [1:0]       driver_step_mode_o,
    output logic [1:0]       phase_a_on_o,
    output logic [1:0]       phase_b_on_o,
    output logic [1:0]       phase_a_pos_to_neg_o,
    output logic [1:0]       phase_b_pos_to_neg_o,
    output logic [3:0]       phase_a_current_o,
    output logic [3:0]       phase_b_current_o
);
    import mdsr_pkg::*;

    // ----------------------------------------
    // Serial clock domain
    // ----------------------------------------
    // There is no data output: the word can only be written.
    logic [12:0] shift_q; // [RULE_02]
    logic [3:0]  bit_count_q;

    always_ff @(posedge serial_clk_i)
    begin
        if (!chip_select_n_i)
        begin
            shift_q <= {shift_data_in_i, shift_q[12:1]}; // [RULE_04] [RULE_05]
        end
    end

    // The count is cleared by the frame's own select, since the serial
    // clock stands still between frames.
    always_ff @(posedge serial_clk_i or posedge chip_select_n_i)
    begin
        if (chip_select_n_i)
        begin
            bit_count_q <= 4'h0;
        end
        else if (bit_count_q != 4'hE)
        begin
            bit_count_q <= bit_count_q + 4'h1; // [RULE_01]
        end
    end

    // The capture reads the count before the same select edge clears it,
    // so a frame of any other length is refused here.
    logic frame_ok_q;

    always_ff @(posedge chip_select_n_i)
    begin
        frame_ok_q <= (bit_count_q == 4'(WORD_BITS)); // [RULE_01]
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic       cs_n_s;
    logic [3:0] mon_s;
    logic       ext_rst_n_s;
    logic [1:0] mode_s;
    logic [1:0] pwm_s;

    mdsr_pin_sync #(
        .W       (1),
        .RST_VAL (1'b1)
    ) u_cs_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (chip_select_n_i),
        .level_o (cs_n_s)
    );

    mdsr_pin_sync #(
        .W       (4),
        .RST_VAL (4'h0)
    ) u_mon_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   ({main_supply_input_high_i, main_supply_input_low_i,
                   first_regulator_feedback_high_i, first_regulator_feedback_low_i}),
        .level_o (mon_s)
    );

    mdsr_pin_sync #(
        .W       (1),
        .RST_VAL (1'b1)
    ) u_ext_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (reset_n_i),
        .level_o (ext_rst_n_s)
    );

    mdsr_pin_sync #(
        .W       (4),
        .RST_VAL (4'h0)
    ) u_drv_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   ({driver_pwm_input_i, driver_mode_select_i}),
        .level_o ({pwm_s, mode_s})
    );

    // ----------------------------------------
    // Reset supervisor
    // ----------------------------------------
    mdsr_sup_state_t        sup_q;
    logic [TIMER_BITS-1:0] timer_q;
    logic                  fb_low;
    logic                  supply_ok;
    logic                  sup_drop;

    assign fb_low    = mon_s[0] | mon_s[2];
    assign supply_ok = mon_s[1] & mon_s[3];

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sup_q   <= MDSR_SUP_HOLD;
            timer_q <= '0;
        end
        else
        begin
            case (sup_q)
                MDSR_SUP_HOLD:
                begin
                    if (!supply_ok)
                    begin
                        timer_q <= '0;
                    end
                    else if (timer_q >= TIMER_BITS'(RELEASE_CYCLES - 1))
                    begin
                        sup_q   <= MDSR_SUP_RUN; // [RULE_15]
                        timer_q <= '0;
                    end
                    else
                    begin
                        timer_q <= timer_q + 1'b1;
                    end
                end
                MDSR_SUP_RUN:
                begin
                    if (!fb_low)
                    begin
                        timer_q <= '0;
                    end
                    else if (timer_q >= TIMER_BITS'(PERSIST_CYCLES - 1))
                    begin
                        sup_q   <= MDSR_SUP_HOLD; // [RULE_11]
                        timer_q <= '0;
                    end
                    else
                    begin
                        timer_q <= timer_q + 1'b1;
                    end
                end
                default:
                begin
                    sup_q   <= MDSR_SUP_HOLD;
                    timer_q <= '0;
                end
            endcase
        end
    end

    assign sup_drop = (sup_q == MDSR_SUP_HOLD);

    // Open-drain style: the pin is only ever pulled low.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            reset_oe_o <= 1'b1;
        end
        else
        begin
            reset_oe_o <= sup_drop; // [RULE_09]
        end
    end

    assign reset_n_o = 1'b0;

    // ----------------------------------------
    // Word capture
    // ----------------------------------------
    logic cs_n_prev_q;
    logic any_reset;
    logic word_load;

    // An external low on the pin resets as well as the internal monitor.
    assign any_reset = sup_drop | ~ext_rst_n_s;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cs_n_prev_q <= 1'b1;
        end
        else
        begin
            cs_n_prev_q <= cs_n_s;
        end
    end

    // The shift register is stable here: the controller gives no clock
    // for the whole select-high interval, which outlasts the sync delay.
    assign word_load = cs_n_s & ~cs_n_prev_q & frame_ok_q; // [RULE_07]

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || any_reset)
        begin
            control_word_o <= WORD_RESET; // [RULE_10] [RULE_16]
        end
        else if (word_load)
        begin
            control_word_o <= shift_q; // [RULE_06] [RULE_01]
        end
    end

    // ----------------------------------------
    // Driver gating
    // ----------------------------------------
    logic drive_on;

    assign drive_on = control_word_o[ENABLE_POS] & ~any_reset;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            second_regulator_and_drive_on_o <= 1'b0;
        end
        else
        begin
            second_regulator_and_drive_on_o <= drive_on; // [RULE_08]
        end
    end

    for (genvar d = 0; d < 2; d++)
    begin : g_drv
        localparam int unsigned B = (d == 0) ? DRV1_BASE : DRV2_BASE;

        always_ff @(posedge clk_i)
        begin
            if (!rst_n_i || !drive_on)
            begin
                driver_step_mode_o[d]     <= 1'b0;
                phase_a_on_o[d]           <= 1'b0; // [RULE_08] [RULE_10]
                phase_b_on_o[d]           <= 1'b0;
                phase_a_pos_to_neg_o[d]   <= 1'b0;
                phase_b_pos_to_neg_o[d]   <= 1'b0;
                phase_a_current_o[2*d+:2] <= 2'h0;
                phase_b_current_o[2*d+:2] <= 2'h0;
            end
            else if (mode_s[d])
            begin
                // Two current bits per phase give the quarter-step levels.
                driver_step_mode_o[d]     <= 1'b1; // [RULE_12] [RULE_14]
                phase_a_on_o[d]           <= 1'b1;
                phase_b_on_o[d]           <= 1'b1;
                phase_a_pos_to_neg_o[d]   <= control_word_o[B+OFS_DIR_A]; // [RULE_17]
                phase_b_pos_to_neg_o[d]   <= control_word_o[B+OFS_DIR_B]; // [RULE_17]
                phase_a_current_o[2*d+:2] <= {control_word_o[B+OFS_I1_A],
                                              control_word_o[B+OFS_I0_A]};
                phase_b_current_o[2*d+:2] <= {control_word_o[B+OFS_I1_B],
                                              control_word_o[B+OFS_I0_B]};
            end
            else
            begin
                // Both bridges run in parallel for the higher DC current.
                driver_step_mode_o[d]     <= 1'b0; // [RULE_12] [RULE_14]
                phase_a_on_o[d]           <= pwm_s[d]; // [RULE_13]
                phase_b_on_o[d]           <= pwm_s[d]; // [RULE_13]
                phase_a_pos_to_neg_o[d]   <= control_word_o[B+OFS_DIR_A];
                phase_b_pos_to_neg_o[d]   <= control_word_o[B+OFS_DIR_A];
                phase_a_current_o[2*d+:2] <= 2'h3;
                phase_b_current_o[2*d+:2] <= 2'h3;
            end
        end
    end
endmodule // mdsr_top

// file: include/mdsr_pkg.sv
// Constants of the motor driver serial port and reset supervisor.
// Assumes a 200 MHz system clock and a serial clock of its own.
//
// How it works
// [RULE_01] Exactly thirteen serial bits make a word; other counts are dropped.
// [RULE_02] The port is write only; no read-back path or serial output exists.
// [RULE_03] Controller drops chip select, then gives thirteen clocks, one bit each.
// [RULE_04] Serial data is shifted on each rising serial clock while select is low.
// [RULE_05] Least significant bit goes first; the thirteenth bit is the top bit.
// [RULE_06] Rising chip select moves the word to the control register at once; the code loads it on the fifth system clock after, via the pin synchroniser.
// [RULE_07] Controller keeps select high one setup plus one hold interval between words.
// [RULE_08] Enable bit low turns off second regulator and all drivers.
// [RULE_09] Active-low reset output follows main supply and first regulator feedback.
// [RULE_10] Any reset forces drivers inactive and reloads the control word.
// [RULE_11] Reset asserts after feedback stays low for the persistence time.
// [RULE_12] Mode select high means step mode, low means DC motor mode.
// [RULE_13] In DC mode a driver is driven from its own PWM pin.
// [RULE_14] Each driver works as DC driver or quarter-step bipolar step driver.
// [RULE_15] Reset is released after feedback is high for the release delay.
// [RULE_16] Enable is the first bit shifted, reset value one.
// [RULE_17] Direction one drives current from positive into negative terminal.

package mdsr_pkg;

    // ----------------------------------------
    // Control word layout
    // ----------------------------------------
    localparam int unsigned WORD_BITS  = 13;
    localparam logic [12:0] WORD_RESET = 13'h0DB7;
    localparam int unsigned ENABLE_POS = 0;
    localparam int unsigned DRV2_BASE  = 1;
    localparam int unsigned DRV1_BASE  = 7;
    localparam int unsigned OFS_I1_B   = 0;
    localparam int unsigned OFS_I0_B   = 1;
    localparam int unsigned OFS_DIR_B  = 2;
    localparam int unsigned OFS_I1_A   = 3;
    localparam int unsigned OFS_I0_A   = 4;
    localparam int unsigned OFS_DIR_A  = 5;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_MHZ     = 200;
    localparam int unsigned PERSIST_US  = 20;
    localparam int unsigned PERSIST_CYC = PERSIST_US * CLK_MHZ;
    localparam int unsigned RELEASE_MS  = 33;
    localparam int unsigned RELEASE_CYC = RELEASE_MS * 1000 * CLK_MHZ;
    localparam int unsigned TIMER_BITS  = 23;

    typedef enum logic [0:0] {
        MDSR_SUP_HOLD = 1'b0,
        MDSR_SUP_RUN  = 1'b1
    } mdsr_sup_state_t;

endpackage

// file: dv/mdsr_ctrl_model.sv
// Controller model that writes control words over the serial link.
// Assumes the link clock idles low and runs only inside frames.
`timescale 1ns/1ps
module mdsr_ctrl_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b1;
    end

    // Each bit is set 80 ns before its rising edge and held 80 ns after it.
    task automatic send(input logic [12:0] w, input int n);
        #1.3;
        cs_n_o = 1'b0;
        #90;
        for (int i = 0; i < n; i++)
        begin
            sdi_o = w[i];
            #80 sclk_o = 1'b1;
            #80 sclk_o = 1'b0;
        end
        #10 sdi_o = ~sdi_o;
        cs_n_o = 1'b1;
        // The off time lets the word reach the latches before the next frame.
        #100;
    endtask
endmodule // mdsr_ctrl_model

// file: dv/mdsr_top_properties.sv
// Port checks of the serial port, reset supervisor and driver gating.
// Assumes a bind onto mdsr_top that hands on both count parameters.
`timescale 1ns/1ps
module mdsr_top_properties
    import mdsr_pkg::*;
#(
    parameter int unsigned RELEASE_CYCLES = 50,
    parameter int unsigned PERSIST_CYCLES = 20
) (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        chip_select_n_i,
    input wire logic        first_regulator_feedback_low_i,
    input wire logic        first_regulator_feedback_high_i,
    input wire logic        main_supply_input_low_i,
    input wire logic        main_supply_input_high_i,
    input wire logic        reset_n_i,
    input wire logic        reset_oe_o,
    input wire logic [1:0]  driver_mode_select_i,
    input wire logic [1:0]  driver_pwm_input_i,
    input wire logic [12:0] control_word_o,
    input wire logic        second_regulator_and_drive_on_o,
    input wire logic [1:0]  driver_step_mode_o,
    input wire logic [1:0]  phase_a_on_o,
    input wire logic [1:0]  phase_a_pos_to_neg_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Run lengths are counted here, since a repetition that long would not unroll.
    logic [31:0] low_cnt_q;
    logic [31:0] ok_cnt_q;
    always_ff @(posedge clk_i)
        if (!rst_n_i || !(first_regulator_feedback_low_i || main_supply_input_low_i))
            low_cnt_q <= '0;
        else
            low_cnt_q <= low_cnt_q + 32'h1;
    always_ff @(posedge clk_i)
        if (!rst_n_i || !(first_regulator_feedback_high_i && main_supply_input_high_i))
            ok_cnt_q <= '0;
        else
            ok_cnt_q <= ok_cnt_q + 32'h1;
    sequence s_live;
        (!reset_oe_o && reset_n_i && $stable(control_word_o)) [*8];
    endsequence
    property p_reload;
        $rose(reset_oe_o) |-> ##[0:3] control_word_o == WORD_RESET;
    endproperty
    a_reload: assert property (p_reload) else $error("word not reloaded");
    property p_off;
        (!reset_n_i) [*6] |-> !second_regulator_and_drive_on_o && phase_a_on_o == 2'b00;
    endproperty
    a_off: assert property (p_off) else $error("drivers active in reset");
    property p_enable;
        s_live |-> second_regulator_and_drive_on_o == control_word_o[0];
    endproperty
    a_enable: assert property (p_enable) else $error("enable mismatch");
    property p_frame;
        $changed(control_word_o) |-> chip_select_n_i;
    endproperty
    a_frame: assert property (p_frame) else $error("word changed in frame");
    property p_step;
        s_live and (control_word_o[0] && driver_mode_select_i[0]) [*8] |->
            driver_step_mode_o[0] && phase_a_pos_to_neg_o[0] == control_word_o[12];
    endproperty
    a_step: assert property (p_step) else $error("step drive wrong");
    property p_dc;
        s_live and (control_word_o[0] && !driver_mode_select_i[1]
            && driver_pwm_input_i[1]) [*8] |-> phase_a_on_o[1];
    endproperty
    a_dc: assert property (p_dc) else $error("pwm not followed");
    property p_persist;
        $rose(reset_oe_o) |-> low_cnt_q >= PERSIST_CYCLES;
    endproperty
    a_persist: assert property (p_persist) else $error("reset too early");
    property p_release;
        $fell(reset_oe_o) |-> ok_cnt_q >= RELEASE_CYCLES;
    endproperty
    a_release: assert property (p_release) else $error("release too early");
endmodule // mdsr_top_properties

bind mdsr_top mdsr_top_properties #(
    .RELEASE_CYCLES(RELEASE_CYCLES),
    .PERSIST_CYCLES(PERSIST_CYCLES)
) u_props (.*);

// file: dv/testbench.sv
// Self-checking bench of the serial port, reset supervisor and drivers.
// Assumes the package, mdsr_top, its checker and the model compile first.
`timescale 1ns/1ps
module testbench;
    import mdsr_pkg::*;
    localparam int REL = 50;
    localparam int PER = 20;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        serial_clk_i, chip_select_n_i, shift_data_in_i;
    logic        first_regulator_feedback_low_i = 1'b0;
    logic        first_regulator_feedback_high_i = 1'b1;
    logic        main_supply_input_low_i = 1'b0;
    logic        main_supply_input_high_i = 1'b1;
    logic        ext_low = 1'b0;
    logic [1:0]  driver_mode_select_i = 2'b11;
    logic [1:0]  driver_pwm_input_i = 2'b00;
    logic        reset_n_i, reset_n_o, reset_oe_o, second_regulator_and_drive_on_o;
    logic [12:0] control_word_o;
    logic [1:0]  driver_step_mode_o, phase_a_on_o, phase_b_on_o;
    logic [1:0]  phase_a_pos_to_neg_o, phase_b_pos_to_neg_o;
    logic [3:0]  phase_a_current_o, phase_b_current_o;
    int          n_mismatch = 0;
    int          n_tests = 0;
    // Open-drain wire with a pull-up; either party may pull it low.
    assign reset_n_i = (reset_oe_o ? reset_n_o : 1'b1) && !ext_low;
    always #2.5 clk_i = ~clk_i;
    mdsr_top #(.RELEASE_CYCLES(REL), .PERSIST_CYCLES(PER)) dut (.*);
    mdsr_ctrl_model u_ctrl (.sclk_o(serial_clk_i), .cs_n_o(chip_select_n_i),
        .sdi_o(shift_data_in_i));

    task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic put(input logic [12:0] w, input int n);
        u_ctrl.send(w, n);
        cyc(10);
    endtask
    task automatic wait_oe(input logic v, output int k);
        for (k = 0; k < 400 && reset_oe_o !== v; k++)
            cyc(1);
        // A wait that runs out leaves the level wrong and is counted here.
        chk("reset level", reset_oe_o, v);
    endtask
    task automatic trip(input logic src, input logic low);
        if (src)
            {main_supply_input_low_i, main_supply_input_high_i} <= {low, !low};
        else
            {first_regulator_feedback_low_i, first_regulator_feedback_high_i} <= {low, !low};
    endtask
    task automatic chk_drv(input logic [12:0] w);
        chk("drive", {1'b0, phase_a_pos_to_neg_o, phase_b_pos_to_neg_o, phase_a_current_o,
            phase_b_current_o}, {1'b0, w[6], w[12], w[3], w[9], w[4], w[5], w[10], w[11],
            w[1], w[2], w[7], w[8]});
    endtask
    task automatic end_sim;
        $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic t_frames;
        logic [12:0] ws [2] = '{13'h1A4D, 13'h05B3};
        int k;
        wait_oe(1'b0, k);
        chk("boot release", k >= REL, 1'b1);
        cyc(8);
        chk("boot word", control_word_o, 13'h0DB7);
        chk("boot enable", second_regulator_and_drive_on_o, 1'b1);
        foreach (ws[i])
        begin
            put(ws[i], 13);
            chk("word", control_word_o, ws[i]);
            chk_drv(ws[i]);
            chk("step", driver_step_mode_o, 2'b11);
        end
        put(13'h0A4C, 12);
        chk("short", control_word_o, 13'h05B3);
        put(13'h0A4C, 13);
        chk("off", {second_regulator_and_drive_on_o, phase_a_on_o, phase_b_on_o},
            13'h0000);
        $display("Test frames done");
    endtask

    task automatic t_dc;
        logic [12:0] w = 13'h1A4D;
        driver_mode_select_i <= 2'b00;
        put(w, 13);
        for (int p = 1; p < 3; p++)
        begin
            driver_pwm_input_i <= p[1:0];
            cyc(8);
            chk("pwm", {phase_a_on_o, phase_b_on_o}, {p[1:0], p[1:0]});
            chk("dc mode", driver_step_mode_o, 2'b00);
        end
        // Both bridges of a DC driver take the phase A direction at full current.
        chk("dc drive", {1'b0, phase_a_pos_to_neg_o, phase_b_pos_to_neg_o, phase_a_current_o,
            phase_b_current_o}, {1'b0, w[6], w[12], w[6], w[12], 8'hFF});
        ext_low <= 1'b1;
        cyc(8);
        chk("ext word", control_word_o, 13'h0DB7);
        chk("ext off", {second_regulator_and_drive_on_o, phase_a_on_o},
            13'h0000);
        ext_low <= 1'b0;
        $display("Test dc done");
    endtask

    task automatic t_brown(input logic src);
        int k;
        // A written word first, so that the reload is seen to happen.
        put(13'h05B3, 13);
        chk("pre word", control_word_o, 13'h05B3);
        trip(src, 1'b1);
        cyc(10);
        trip(src, 1'b0);
        cyc(30);
        chk("glitch", reset_oe_o, 1'b0);
        trip(src, 1'b1);
        wait_oe(1'b1, k);
        chk("persist", k >= PER, 1'b1);
        chk("reload", control_word_o, 13'h0DB7);
        chk("pin", reset_n_i, 1'b0);
        put(13'h1A4D, 13);
        chk("held", control_word_o, 13'h0DB7);
        trip(src, 1'b0);
        wait_oe(1'b0, k);
        chk("release", k >= REL, 1'b1);
        $display("Test brownout %0d done", src);
    endtask

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_frames();
        t_dc();
        t_brown(1'b0);
        t_brown(1'b1);
        end_sim();
    end
    // Nine frames and the waits take about 25 us; the limit leaves ample slack.
    initial
    begin
        #100000;
        n_mismatch++;
        end_sim();
    end
endmodule // testbench
